// [tmr8_pkg.sv]
// Constants, register map and mode decoding for the 8-bit timer block.
package tmr8_pkg;
  // ----------------------------------------------------------------
  // Register indices on the software port.
  // ----------------------------------------------------------------
  localparam logic [2:0] REG_CTL_A = 3'h0;
  localparam logic [2:0] REG_CTL_B = 3'h1;
  localparam logic [2:0] REG_COUNT = 3'h2;
  localparam logic [2:0] REG_CMP_A = 3'h3;
  localparam logic [2:0] REG_CMP_B = 3'h4;
  localparam logic [2:0] REG_MASK  = 3'h5;
  localparam logic [2:0] REG_FLAGS = 3'h6;
  // ----------------------------------------------------------------
  // Field positions.
  // ----------------------------------------------------------------
  localparam int B_FORCE_A = 7;
  localparam int B_FORCE_B = 6;
  localparam int B_WGM2    = 3;
  localparam int B_MATCH_B = 2;
  localparam int B_MATCH_A = 1;
  localparam int B_OVF     = 0;
  // Reset values and fixed counter points.
  localparam logic [7:0] RST_BYTE  = 8'h00;
  localparam logic [2:0] RST_IRQ3  = 3'h0;
  localparam logic [7:0] CNT_MAX   = 8'hFF;
  localparam logic [7:0] CNT_BOT   = 8'h00;
  localparam logic [7:0] CNT_ONE   = 8'h01;
  // ----------------------------------------------------------------
  // Clock select codes and waveform modes.
  // ----------------------------------------------------------------
  localparam logic [2:0] CS_STOP = 3'h0;
  localparam logic [2:0] CS_DIR  = 3'h1;
  localparam logic [2:0] CS_D8   = 3'h2;
  localparam logic [2:0] CS_D64  = 3'h3;
  localparam logic [2:0] CS_D256 = 3'h4;
  localparam logic [2:0] CS_D1K  = 3'h5;
  localparam logic [2:0] CS_FALL = 3'h6;
  localparam logic [2:0] CS_RISE = 3'h7;
  localparam logic [2:0] WM_CTC  = 3'h2;
  localparam logic [2:0] WM_PC_A = 3'h5;
  localparam logic [2:0] WM_FP_A = 3'h7;
  localparam logic [1:0] WM_PC   = 2'h1;
  // Output mode actions on a compare match.
  localparam logic [1:0] OM_TOG  = 2'h1;
  localparam logic [1:0] OM_CLR  = 2'h2;
  localparam logic [1:0] OM_SET  = 2'h3;
  // Prescaler tap widths in bits for divide by 8, 64, 256 and 1024: 3, 6, 8 and 10.
  localparam int PS_W8 = 3;
  localparam int PS_W64 = 6;
  localparam int PS_W256 = 8;
  localparam int PS_W1K = 10;

  // Odd modes are the PWM modes.
  function automatic logic is_pwm(input logic [2:0] wm);
    is_pwm = wm[0];
  endfunction : is_pwm

  // Modes that take the top value from compare register A.
  function automatic logic top_cmp_a(input logic [2:0] wm);
    top_cmp_a = (wm == WM_CTC) || (wm == WM_PC_A) || (wm == WM_FP_A);
  endfunction : top_cmp_a

  // New output level for a match under a non-PWM output mode.
  function automatic logic wave_act(input logic [1:0] om, input logic cur);
    case (om)
      OM_TOG:  wave_act = ~cur;
      OM_CLR:  wave_act = 1'b0;
      OM_SET:  wave_act = 1'b1;
      default: wave_act = cur;
    endcase
  endfunction : wave_act
endpackage : tmr8_pkg

// [tmr8_prescale.sv]
// Free-running prescaler that gives one-cycle tick enables.
`timescale 1ns/1ps
`default_nettype none
module tmr8_prescale
  import tmr8_pkg::*;
(
  // Clock and reset.
  input  wire logic REF_CLK,
  input  wire logic SYS_RST,
  // Tick enables.
  output logic      tick_d8,
  output logic      tick_d64,
  output logic      tick_d256,
  output logic      tick_d1k
);
  typedef struct packed {
    logic [PS_W1K-1:0] cnt;
  } tmr8_ps_t;

  tmr8_ps_t st_ff;
  tmr8_ps_t nxt_st;

  // The divider counts every cycle; a tap fires when its low bits are all ones.
  always_comb
  begin
    nxt_st     = st_ff;
    nxt_st.cnt = st_ff.cnt + 1'b1;
  end

  always_ff @(posedge REF_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
      st_ff <= '0;
    else
      st_ff <= nxt_st;
  end

  // Tap decodes for the four divided rates.
  assign tick_d8   = &st_ff.cnt[PS_W8-1:0];
  assign tick_d64  = &st_ff.cnt[PS_W64-1:0];
  assign tick_d256 = &st_ff.cnt[PS_W256-1:0];
  assign tick_d1k  = &st_ff.cnt[PS_W1K-1:0];
endmodule : tmr8_prescale
`default_nettype wire

// [tmr8_extsync.sv]
// Synchroniser and edge detector for the external count input.
`timescale 1ns/1ps
`default_nettype none
module tmr8_extsync
  import tmr8_pkg::*;
(
  // Clock and reset.
  input  wire logic REF_CLK,
  input  wire logic SYS_RST,
  // Pin and edge pulses.
  input  wire logic ext_in,
  output logic      ext_rise,
  output logic      ext_fall
);
  typedef struct packed {
    logic meta;
    logic sync;
    logic last;
  } tmr8_sync_t;

  tmr8_sync_t st_ff;
  tmr8_sync_t nxt_st;

  // Two flops settle the pin; a third holds the previous level for edges.
  always_comb
  begin
    nxt_st      = st_ff;
    nxt_st.meta = ext_in;
    nxt_st.sync = st_ff.meta;
    nxt_st.last = st_ff.sync;
  end

  always_ff @(posedge REF_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
      st_ff <= '0;
    else
      st_ff <= nxt_st;
  end

  // One pulse per settled edge.
  assign ext_rise = st_ff.sync & ~st_ff.last;
  assign ext_fall = ~st_ff.sync & st_ff.last;
endmodule : tmr8_extsync
`default_nettype wire

// [tmr8_top.sv]
// Register file, counter, compare units and interrupt logic of the timer.
`timescale 1ns/1ps
`default_nettype none
module tmr8_top
  import tmr8_pkg::*;
(
  // Clock and reset.
  input  wire logic       REF_CLK,
  input  wire logic       SYS_RST,
  // Register port.
  input  wire logic [2:0] REG_ADDR,
  input  wire logic [7:0] REG_WDATA,
  input  wire logic       REG_WR,
  input  wire logic       REG_RD,
  output logic      [7:0] REG_RDATA,
  // Processor side interrupt handling.
  input  wire logic       GLOBAL_IRQ_EN,
  input  wire logic [2:0] VECTOR_ACK,
  output logic            IRQ_OUT,
  // Pins.
  input  wire logic       EXTERNAL_COUNT_INPUT,
  output logic            CHANNEL_A_WAVE_OUT,
  output logic            CHANNEL_B_WAVE_OUT
);
  // ----------------------------------------------------------------
  // State.
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] ctl_a;
    logic       wgm2;
    logic [2:0] cs;
    logic [7:0] cnt;
    logic [7:0] cmp_a;
    logic [7:0] cmp_b;
    logic [2:0] mask;
    logic [2:0] flags;
    logic       down;
    logic       blk;
    logic       wave_a;
    logic       wave_b;
    logic       irq;
    logic [7:0] rdata;
  } tmr8_state_t;

  tmr8_state_t st_ff;
  tmr8_state_t nxt_st;

  logic       d8;
  logic       d64;
  logic       d256;
  logic       d1k;
  logic       e_rise;
  logic       e_fall;
  logic       tick;
  logic [2:0] wm;
  logic [7:0] top;
  logic       hit_a;
  logic       hit_b;
  logic       frc_a;
  logic       frc_b;
  logic       wr_b;
  logic [2:0] wm_new;
  logic [2:0] ev;
  logic [2:0] sw_clr;
  logic       wrap;

  // ----------------------------------------------------------------
  // Clock sources.
  // ----------------------------------------------------------------
  tmr8_prescale u_ps (
    .REF_CLK   (REF_CLK),
    .SYS_RST   (SYS_RST),
    .tick_d8   (d8),
    .tick_d64  (d64),
    .tick_d256 (d256),
    .tick_d1k  (d1k)
  );

  tmr8_extsync u_ext (
    .REF_CLK  (REF_CLK),
    .SYS_RST  (SYS_RST),
    .ext_in   (EXTERNAL_COUNT_INPUT),
    .ext_rise (e_rise),
    .ext_fall (e_fall)
  );

  // Clock select picks the tick enable for the counter.
  always_comb
  begin
    case (st_ff.cs)
      CS_STOP: tick = 1'b0;
      CS_DIR:  tick = 1'b1;
      CS_D8:   tick = d8;
      CS_D64:  tick = d64;
      CS_D256: tick = d256;
      CS_D1K:  tick = d1k;
      CS_FALL: tick = e_fall;
      CS_RISE: tick = e_rise;
      default: tick = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // Mode, compare and strobe decoding.
  // ----------------------------------------------------------------
  // The mode joins the high bit from control B with the low bits of control A.
  assign wm     = {st_ff.wgm2, st_ff.ctl_a[1:0]};
  assign top    = top_cmp_a(wm) ? st_ff.cmp_a : CNT_MAX;
  assign hit_a  = tick && !st_ff.blk && (st_ff.cnt == st_ff.cmp_a);
  assign hit_b  = tick && !st_ff.blk && (st_ff.cnt == st_ff.cmp_b);
  assign wr_b   = REG_WR && (REG_ADDR == REG_CTL_B);
  assign wm_new = {REG_WDATA[B_WGM2], st_ff.ctl_a[1:0]};
  assign frc_a  = wr_b && REG_WDATA[B_FORCE_A] && !is_pwm(wm_new);
  assign frc_b  = wr_b && REG_WDATA[B_FORCE_B] && !is_pwm(wm_new);
  assign wrap   = (st_ff.cnt == top);
  assign sw_clr = (REG_WR && (REG_ADDR == REG_FLAGS)) ? REG_WDATA[2:0] : RST_IRQ3;

  // Events that set flags; a forced match is not among them.
  always_comb
  begin
    ev            = RST_IRQ3;
    ev[B_MATCH_A] = hit_a;
    ev[B_MATCH_B] = hit_b;
    if (tick)
    begin
      if (wm[1:0] == WM_PC)
        ev[B_OVF] = st_ff.down && (st_ff.cnt == CNT_ONE);
      else if (wm == WM_FP_A)
        ev[B_OVF] = wrap;
      else
        ev[B_OVF] = (st_ff.cnt == CNT_MAX);
    end
  end

  // ----------------------------------------------------------------
  // Next state.
  // ----------------------------------------------------------------
  always_comb
  begin
    nxt_st       = st_ff;
    nxt_st.rdata = RST_BYTE;
    // Counter sequence for the selected mode.
    if (tick)
    begin
      nxt_st.blk = 1'b0;
      if (wm[1:0] == WM_PC)
      begin
        if (!st_ff.down && wrap)
        begin
          nxt_st.down = 1'b1;
          nxt_st.cnt  = st_ff.cnt - 1'b1;
        end
        else if (st_ff.down && (st_ff.cnt == CNT_BOT))
        begin
          nxt_st.down = 1'b0;
          nxt_st.cnt  = CNT_ONE;
        end
        else if (st_ff.down)
          nxt_st.cnt = st_ff.cnt - 1'b1;
        else
          nxt_st.cnt = st_ff.cnt + 1'b1;
      end
      else
      begin
        nxt_st.down = 1'b0;
        nxt_st.cnt  = wrap ? CNT_BOT : st_ff.cnt + 1'b1;
      end
    end
    // Outputs follow matches and forced matches in non-PWM modes only.
    if (!is_pwm(wm) && (hit_a || frc_a))
      nxt_st.wave_a = wave_act(st_ff.ctl_a[7:6], st_ff.wave_a);
    if (!is_pwm(wm) && (hit_b || frc_b))
      nxt_st.wave_b = wave_act(st_ff.ctl_a[5:4], st_ff.wave_b);
    // Register writes; a counter write wins over the tick and arms the block.
    if (REG_WR)
    begin
      case (REG_ADDR)
        REG_CTL_A: nxt_st.ctl_a = REG_WDATA;
        REG_CTL_B:
        begin
          nxt_st.wgm2 = REG_WDATA[B_WGM2];
          nxt_st.cs   = REG_WDATA[2:0];
        end
        REG_COUNT:
        begin
          nxt_st.cnt = REG_WDATA;
          nxt_st.blk = 1'b1;
        end
        REG_CMP_A: nxt_st.cmp_a = REG_WDATA;
        REG_CMP_B: nxt_st.cmp_b = REG_WDATA;
        REG_MASK:  nxt_st.mask  = REG_WDATA[2:0];
        default:   nxt_st.blk   = nxt_st.blk;   // Keeps the tick's release of the block.
      endcase
    end
    // Sticky flags: a new event wins over a clear in the same cycle.
    nxt_st.flags = (st_ff.flags & ~(sw_clr | VECTOR_ACK)) | ev;
    nxt_st.irq   = GLOBAL_IRQ_EN && |(nxt_st.flags & nxt_st.mask);
    // Read data for the cycle after the strobe; unmapped reads give zero.
    if (REG_RD)
    begin
      case (REG_ADDR)
        REG_CTL_A: nxt_st.rdata = st_ff.ctl_a;
        REG_CTL_B: nxt_st.rdata = {4'h0, st_ff.wgm2, st_ff.cs};
        REG_COUNT: nxt_st.rdata = st_ff.cnt;
        REG_CMP_A: nxt_st.rdata = st_ff.cmp_a;
        REG_CMP_B: nxt_st.rdata = st_ff.cmp_b;
        REG_MASK:  nxt_st.rdata = {5'h00, st_ff.mask};
        REG_FLAGS: nxt_st.rdata = {5'h00, st_ff.flags};
        default:   nxt_st.rdata = RST_BYTE;
      endcase
    end
  end

  // State register.
  always_ff @(posedge REF_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
      st_ff <= '0;
    else
      st_ff <= nxt_st;
  end

  // Outputs straight from flip-flops.
  assign REG_RDATA          = st_ff.rdata;
  assign IRQ_OUT            = st_ff.irq;
  assign CHANNEL_A_WAVE_OUT = st_ff.wave_a;
  assign CHANNEL_B_WAVE_OUT = st_ff.wave_b;

  // ----------------------------------------------------------------
  // Checks.
  // ----------------------------------------------------------------
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (SYS_RST);

  // A stopped timer with a forced write of both strobes.
  sequence s_force_stopped;
    wr_b && REG_WDATA[B_FORCE_A] && REG_WDATA[B_FORCE_B] && !REG_WDATA[B_WGM2]
      && !st_ff.ctl_a[0] && (st_ff.cs == CS_STOP) && (REG_WDATA[2:0] == CS_STOP)
      && !(|VECTOR_ACK);
  endsequence

  // A counter write that lands on compare A while counting every cycle.
  sequence s_write_on_match;
    REG_WR && (REG_ADDR == REG_COUNT) && (REG_WDATA == st_ff.cmp_a)
      && (st_ff.cs == CS_DIR) && !st_ff.flags[B_MATCH_A] && (st_ff.cnt != st_ff.cmp_a);
  endsequence

  a_force_no_flag: assert property (s_force_stopped |=> (st_ff.flags == $past(st_ff.flags))
    && (st_ff.cnt == $past(st_ff.cnt)))
    else $error("Forced match changed flags or counter.");

  a_force_toggle: assert property ((s_force_stopped and (st_ff.ctl_a[7:6] == OM_TOG))
    |=> CHANNEL_A_WAVE_OUT != $past(CHANNEL_A_WAVE_OUT))
    else $error("Forced match did not toggle channel A.");

  a_pwm_no_force: assert property (wr_b && REG_WDATA[B_FORCE_B] && st_ff.ctl_a[0]
    |=> $stable(CHANNEL_B_WAVE_OUT))
    else $error("Forced match acted in a PWM mode.");

  a_ctlb_read_zero: assert property (REG_RD && (REG_ADDR == REG_CTL_B)
    |=> REG_RDATA[7:4] == 4'h0)
    else $error("Control B upper bits read nonzero.");

  a_flag_read_zero: assert property (REG_RD && ((REG_ADDR == REG_MASK) || (REG_ADDR == REG_FLAGS))
    |=> REG_RDATA[7:3] == 5'h00)
    else $error("Reserved mask or flag bits read nonzero.");

  a_stop_holds: assert property ((st_ff.cs == CS_STOP) && !REG_WR ##1 !REG_WR
    |=> $stable(st_ff.cnt))
    else $error("Stopped counter moved.");

  a_count_write: assert property (REG_WR && (REG_ADDR == REG_COUNT) && !REG_RD
    ##1 REG_RD && (REG_ADDR == REG_COUNT) |=> REG_RDATA == $past(REG_WDATA, 2))
    else $error("Counter write not read back.");

  a_match_blocked: assert property (s_write_on_match ##1 !VECTOR_ACK[B_MATCH_A]
    |=> !st_ff.flags[B_MATCH_A])
    else $error("Counter write did not block the next match.");

  a_match_b_flag: assert property (hit_b |=> st_ff.flags[B_MATCH_B])
    else $error("Compare B match did not set its flag.");

  a_irq_level: assert property (##1 IRQ_OUT == ($past(GLOBAL_IRQ_EN)
    && |(st_ff.flags & st_ff.mask)))
    else $error("Interrupt output disagrees with flags and mask.");
endmodule : tmr8_top
`default_nettype wire

// [tmr8_tb.sv]
// Self-checking testbench for the 8-bit timer registers, counter, compare and interrupt logic.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import tmr8_pkg::*;
  // ----------------------------------------------------------------
  // Clock, reset and design connections.
  // ----------------------------------------------------------------
  logic       ref_clk   = 1'b0;
  logic       sys_rst   = 1'b1;
  logic [2:0] reg_addr  = 3'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_wr    = 1'b0;
  logic       reg_rd    = 1'b0;
  logic [7:0] reg_rdata;
  logic       global_en = 1'b0;
  logic [2:0] vec_ack   = 3'h0;
  logic       irq_out;
  logic       ext_pin   = 1'b0;
  logic       wave_a;
  logic       wave_b;
  int         failures  = 0;
  int         cmp_count = 0;
  int         n;
  logic [2:0] ra;
  logic [7:0] rv;
  logic [7:0] rb;

  // Clock at 200 MHz.
  always #2.5 ref_clk = ~ref_clk;

  tmr8_top i_tmr8_top (
    .REF_CLK              (ref_clk),
    .SYS_RST              (sys_rst),
    .REG_ADDR             (reg_addr),
    .REG_WDATA            (reg_wdata),
    .REG_WR               (reg_wr),
    .REG_RD               (reg_rd),
    .REG_RDATA            (reg_rdata),
    .GLOBAL_IRQ_EN        (global_en),
    .VECTOR_ACK           (vec_ack),
    .IRQ_OUT              (irq_out),
    .EXTERNAL_COUNT_INPUT (ext_pin),
    .CHANNEL_A_WAVE_OUT   (wave_a),
    .CHANNEL_B_WAVE_OUT   (wave_b)
  );

  // ----------------------------------------------------------------
  // Bus tasks, expectations and comparisons.
  // ----------------------------------------------------------------
  task automatic tick(input int c);
    repeat (c) @(posedge ref_clk);
  endtask : tick

  // Waits whole cycles, then steps off the edge so outputs have settled.
  task automatic see(input int c);
    tick(c);
    #1;
  endtask : see

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe, so sample there.
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : rd

  // Write, then read the same index on the very next strobe.
  task automatic wr_rd(input logic [2:0] a, input logic [7:0] d, output logic [7:0] q);
    @(posedge ref_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    q = reg_rdata;
  endtask : wr_rd

  task automatic ack(input logic [2:0] v);
    @(posedge ref_clk);
    vec_ack <= v;
    @(posedge ref_clk);
    vec_ack <= 3'h0;
  endtask : ack

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
    cmp_count++;
    if (got !== exp)
    begin
      failures++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk8

  task automatic chk1(input logic got, input logic exp, input string what);
    cmp_count++;
    if (got !== exp)
    begin
      failures++;
      $display("MISMATCH t=%0t %s got %b exp %b", $time, what, got, exp);
    end
  endtask : chk1

  // Counts from a free-running prescaler may land one tick either side.
  task automatic chk_rng(input logic [7:0] got, input int lo, input int hi, input string what);
    cmp_count++;
    if ((^got === 1'bx) || (got < lo) || (got > hi))
    begin
      failures++;
      $display("MISMATCH t=%0t %s got %h range %0d..%0d", $time, what, got, lo, hi);
    end
  endtask : chk_rng

  task automatic rdchk(input logic [2:0] a, input logic [7:0] exp, input string what);
    logic [7:0] v;
    rd(a, v);
    chk8(v, exp, what);
  endtask : rdchk

  // Read-back value of a register after a write of d.
  function automatic logic [7:0] exp_read(input logic [2:0] a, input logic [7:0] d);
    case (a)
      REG_CTL_B: exp_read = d & 8'h0F;
      REG_MASK:  exp_read = d & 8'h07;
      3'h7:      exp_read = 8'h00;
      default:   exp_read = d;
    endcase
  endfunction : exp_read

  // Division ratio of each internal clock select code.
  function automatic int div_of(input logic [2:0] cs);
    case (cs)
      CS_DIR:  div_of = 1;
      CS_D8:   div_of = 8;
      CS_D64:  div_of = 64;
      CS_D256: div_of = 256;
      CS_D1K:  div_of = 1024;
      default: div_of = 0;
    endcase
  endfunction : div_of

  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : end_sim

  // Guards the whole run against a hang.
  initial
  begin
    tick(100000);
    failures++;
    $display("MISMATCH t=%0t run limit reached", $time);
    end_sim();
  end

  // ----------------------------------------------------------------
  // Main sequence.
  // ----------------------------------------------------------------
  initial
  begin
    void'($urandom(84139));
    tick(6);
    sys_rst <= 1'b0;
    see(0);
    chk1(irq_out, 1'b0, "irq after reset");
    for (int i = 0; i < 8; i++)
    begin
      rdchk(3'(i), 8'h00, "reset value");
    end
    // Random register traffic with the counter stopped, plus the unmapped index.
    for (int i = 0; i < 16; i++)
    begin
      ra = 3'(1 + ($urandom % 5));
      rv = 8'($urandom);
      if (i == 15)
        ra = 3'h7;
      if (ra == REG_CTL_B)
        rv = rv & 8'hF8;
      wr_rd(ra, rv, rb);
      chk8(rb, exp_read(ra, rv), "register read back");
    end
    wr(REG_MASK, 8'h00);
    // Internal clock sources: stopped, direct and each prescaler tap.
    for (int cs = 0; cs <= 5; cs++)
    begin
      wr(REG_COUNT, 8'h00);
      wr(REG_CTL_B, 8'(cs));
      tick((cs == 0) ? 20 : 8 * div_of(3'(cs)) - 2);
      wr(REG_CTL_B, 8'h00);
      rd(REG_COUNT, rv);
      chk_rng(rv, (cs == 0) ? 0 : 7, (cs == 0) ? 0 : 9, "prescaled count");
    end
    // External pin edges, falling then rising, five of each.
    for (int e = 6; e <= 7; e++)
    begin
      wr(REG_COUNT, 8'h00);
      wr(REG_CTL_B, 8'(e));
      for (int k = 0; k < 5; k++)
      begin
        tick(4);
        ext_pin <= 1'b1;
        tick(4);
        ext_pin <= 1'b0;
      end
      tick(6);
      wr(REG_CTL_B, 8'h00);
      rdchk(REG_COUNT, 8'h05, "external edge count");
    end
    // Matches during the counting runs may have left flags set.
    wr(REG_FLAGS, 8'h07);
    // Forced matches under toggle, set and clear output modes.
    wr(REG_CTL_A, 8'h50);
    wr(REG_CTL_B, 8'h80);
    see(2);
    chk1(wave_a, 1'b1, "force a toggle");
    chk1(wave_b, 1'b0, "force a leaves b");
    rdchk(REG_CTL_B, 8'h00, "force bits read");
    wr(REG_CTL_B, 8'h40);
    see(2);
    chk1(wave_b, 1'b1, "force b toggle");
    wr(REG_CTL_A, 8'h52);
    wr(REG_CMP_A, 8'h33);
    wr(REG_COUNT, 8'h33);
    wr(REG_CTL_B, 8'hC0);
    see(2);
    chk1(wave_a, 1'b0, "force a in ctc");
    chk1(wave_b, 1'b0, "force b in ctc");
    rdchk(REG_COUNT, 8'h33, "force keeps count");
    rdchk(REG_FLAGS, 8'h00, "force sets no flag");
    wr(REG_CTL_A, 8'hF0);
    wr(REG_CTL_B, 8'hC0);
    see(2);
    chk1(wave_a, 1'b1, "force set a");
    wr(REG_CTL_A, 8'hA0);
    wr(REG_CTL_B, 8'hC0);
    see(2);
    chk1(wave_b, 1'b0, "force clear b");
    wr(REG_CTL_A, 8'hF3);
    wr(REG_CTL_B, 8'hC0);
    see(2);
    chk1(wave_a, 1'b0, "no force in pwm");
    wr(REG_CTL_B, 8'h00);
    wr(REG_CTL_A, 8'h00);
    // A counter write suppresses the match on the next tick.
    wr(REG_CMP_A, 8'h40);
    wr(REG_CMP_B, 8'hF8);
    wr(REG_CTL_B, 8'h01);
    wr(REG_COUNT, 8'h40);
    tick(2);
    wr(REG_CTL_B, 8'h00);
    rdchk(REG_FLAGS, 8'h00, "match blocked after count write");
    wr(REG_CTL_B, 8'h01);
    wr(REG_COUNT, 8'h3F);
    tick(2);
    wr(REG_CTL_B, 8'h00);
    rdchk(REG_FLAGS, 8'h02, "match a flag");
    wr(REG_FLAGS, 8'h02);
    // Run through both matches and the overflow, waiting for the interrupt.
    wr(REG_CMP_A, 8'hF4);
    wr(REG_COUNT, 8'hF0);
    wr(REG_MASK, 8'h01);
    global_en <= 1'b1;
    wr(REG_CTL_B, 8'h01);
    n = 0;
    while (irq_out !== 1'b1 && n < 100)
    begin
      see(1);
      n++;
    end
    if (n < 100)
    begin
      wr(REG_CTL_B, 8'h00);
      rdchk(REG_FLAGS, 8'h07, "all flags set");
      @(posedge ref_clk) global_en <= 1'b0;
      see(2);
      chk1(irq_out, 1'b0, "global enable low");
      @(posedge ref_clk) global_en <= 1'b1;
      wr(REG_MASK, 8'h00);
      see(2);
      chk1(irq_out, 1'b0, "mask clear");
      wr(REG_MASK, 8'h04);
      see(2);
      chk1(irq_out, 1'b1, "mask b");
      wr(REG_FLAGS, 8'h02);
      rdchk(REG_FLAGS, 8'h05, "write one clears a");
      ack(3'h4);
      rdchk(REG_FLAGS, 8'h01, "vector clears b");
      see(1);
      chk1(irq_out, 1'b0, "irq after b cleared");
      ack(3'h1);
      rdchk(REG_FLAGS, 8'h00, "vector clears overflow");
    end
    else
    begin
      failures++;
      $display("MISMATCH t=%0t interrupt never raised", $time);
    end
    end_sim();
  end
endmodule : testbench
`default_nettype wire
